/* File: logic/srx_align_demux.sv */
`default_nettype none
module srx_align_demux (
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic byte_sync_enable,
  input wire logic protocol_mode_select,
  input wire logic rx_decode_enable,
  input wire logic force_word_realign,
  input wire logic disable_word_align,
  input wire logic [1:0] rx_clock_select,
  input wire logic [3:0] peer_rx_clocks,
  input wire logic cdr_data_locked,
  output logic cdr_lock_to_ref,
  output logic word_sync_status,
  output logic demux_sync_status,
  output logic shared_rx_clock,
  input wire logic recovered_clock_a,
  input wire logic [9:0] rx_deser_bits,
  output logic serdes_link_sync,
  output logic comma_detect_flag,
  output logic code_violation_flag,
  output logic [31:0] rx_word_out,
  output logic [3:0] rx_special_flags,
  output logic [3:0] rx_bit9_flags,
  output logic [3:0] align_marker_bits,
  output logic rx_word_valid
);

  // ===================================================================
  // control levels into the link domain
  logic [6:0] ctl_meta;
  logic [6:0] ctl_sync;
  logic rst_rx;
  logic ce_rx;
  logic bs_en;
  logic xaui;
  logic dec_en;
  logic force_lvl;
  logic no_align;

  always_ff @(posedge recovered_clock_a) begin
    ctl_meta <= {reset, clk_en, byte_sync_enable, protocol_mode_select,
                 rx_decode_enable, force_word_realign, disable_word_align};
    ctl_sync <= ctl_meta;
  end

  assign rst_rx = ctl_sync[6];
  assign ce_rx = ctl_sync[5];
  assign bs_en = ctl_sync[4];
  assign xaui = ctl_sync[3] == srx_pkg::MODE_XAUI;
  assign dec_en = ctl_sync[2];
  assign force_lvl = ctl_sync[1];
  assign no_align = ctl_sync[0];

  // ===================================================================
  // byte aligner
  logic [9:0] prev_bits;
  logic [19:0] win;
  logic hit;
  logic [3:0] hit_off;
  logic [3:0] byte_off;
  logic [3:0] use_off;
  logic bs_done;
  logic bs_en_d;
  logic take;
  logic [9:0] char;

  assign win = {rx_deser_bits, prev_bits};

  // lowest offset wins when two commas overlap the window
  always_comb begin
    hit = 1'b0;
    hit_off = srx_pkg::OFF_RESET;
    for (int k = 9; k >= 0; k--) begin
      if (srx_pkg::srx_is_comma(win[k +: 7])) begin
        hit = 1'b1;
        hit_off = 4'(k);
      end
    end
  end

  assign take = hit && (bs_en || !bs_done);
  assign use_off = take ? hit_off : byte_off;
  assign char = win[use_off +: 10];

  always_ff @(posedge recovered_clock_a) begin
    if (rst_rx) begin
      prev_bits <= '0;
      byte_off <= srx_pkg::OFF_RESET;
    end else if (ce_rx) begin
      prev_bits <= rx_deser_bits;
      byte_off <= use_off;
    end
  end

  // one alignment is owed after an enable window that saw no comma
  always_ff @(posedge recovered_clock_a) begin
    if (rst_rx) begin
      bs_done <= 1'b1;
      bs_en_d <= 1'b0;
    end else if (ce_rx) begin
      bs_en_d <= bs_en;
      if (bs_en && !bs_en_d) begin
        bs_done <= take;
      end else if (take) begin
        bs_done <= 1'b1;
      end
    end
  end

  // ===================================================================
  // character decode
  logic [5:0] code6;
  logic [3:0] code4;
  logic [5:0] r6;
  logic [3:0] r4;
  logic is_k;
  logic ch_cv;
  logic ch_comma;
  logic ch_b8;
  logic ch_b9;
  logic [7:0] ch_byte;

  assign code6 = {char[0], char[1], char[2], char[3], char[4], char[5]};
  assign code4 = {char[6], char[7], char[8], char[9]};
  assign r6 = srx_pkg::srx_dec6(code6);
  // K28 in positive disparity carries an inverted tail
  assign r4 = srx_pkg::srx_dec4(code6 == srx_pkg::K28_POS ? ~code4 : code4);
  assign is_k = (code6 == srx_pkg::K28_NEG) || (code6 == srx_pkg::K28_POS)
    || (((code4 == srx_pkg::ALT7_NEG) || (code4 == srx_pkg::ALT7_POS))
        && srx_pkg::srx_kx7(code6));

  always_ff @(posedge recovered_clock_a) begin
    if (rst_rx) begin
      ch_cv <= 1'b0;
      ch_comma <= 1'b0;
      ch_b8 <= 1'b0;
      ch_b9 <= 1'b0;
      ch_byte <= '0;
    end else if (ce_rx) begin
      ch_comma <= srx_pkg::srx_is_comma(char[6:0]);
      if (dec_en) begin
        ch_byte <= {r4[2:0], r6[4:0]};
        ch_b8 <= is_k;
        ch_cv <= !(r6[5] && r4[3]);
        ch_b9 <= 1'b0;
      end else begin
        ch_byte <= char[7:0];
        ch_b8 <= char[8];
        ch_b9 <= char[9];
        ch_cv <= 1'b0;
      end
    end
  end

  assign comma_detect_flag = ch_comma;
  assign code_violation_flag = ch_cv;

  // ===================================================================
  // link synchronisation
  srx_pkg::srx_sync_e sstate;
  logic [1:0] acq_cnt;
  logic [2:0] bad_cnt;
  logic [2:0] good_cnt;
  logic [2:0] good_need;
  logic word_bad;
  logic unit_tick;
  logic unit_bad;
  logic synced;
  logic lsm_on;
  logic [1:0] phase;
  logic hunt;
  logic align_now;
  logic word_end;

  assign synced = sstate == srx_pkg::SRX_SYNC;
  // raw characters carry no violation info, so XAUI cannot run then
  assign lsm_on = dec_en || !xaui;
  assign word_end = (phase == srx_pkg::SLOT_LAST) && !align_now;
  // FC judges whole words, XAUI every code-group
  assign unit_tick = xaui || word_end;
  assign unit_bad = xaui ? ch_cv : (word_bad || ch_cv);
  assign good_need = xaui ? srx_pkg::XAUI_GOOD : srx_pkg::FC_GOOD;

  always_ff @(posedge recovered_clock_a) begin
    if (rst_rx) begin
      sstate <= srx_pkg::SRX_LOS;
      acq_cnt <= '0;
      bad_cnt <= '0;
      good_cnt <= '0;
    end else if (ce_rx) begin
      if (!lsm_on) begin
        sstate <= srx_pkg::SRX_LOS;
        acq_cnt <= '0;
      end else begin
        case (sstate)
          srx_pkg::SRX_LOS, srx_pkg::SRX_ACQ: begin
            bad_cnt <= '0;
            good_cnt <= '0;
            if (ch_cv) begin
              sstate <= srx_pkg::SRX_LOS;
              acq_cnt <= '0;
            end else if (ch_comma) begin
              if (acq_cnt == srx_pkg::ACQ_SETS - 2'h1) begin
                sstate <= srx_pkg::SRX_SYNC;
                acq_cnt <= '0;
              end else begin
                sstate <= srx_pkg::SRX_ACQ;
                acq_cnt <= acq_cnt + 2'h1;
              end
            end
          end
          srx_pkg::SRX_SYNC: begin
            if (unit_tick && unit_bad) begin
              good_cnt <= '0;
              if (bad_cnt == srx_pkg::LOSS_BAD - 3'h1) begin
                sstate <= srx_pkg::SRX_LOS;
                bad_cnt <= '0;
              end else begin
                bad_cnt <= bad_cnt + 3'h1;
              end
            end else if (unit_tick && (bad_cnt != '0)) begin
              // enough good units in a row forgive one bad one
              if (good_cnt == good_need - 3'h1) begin
                bad_cnt <= bad_cnt - 3'h1;
                good_cnt <= '0;
              end else begin
                good_cnt <= good_cnt + 3'h1;
              end
            end
          end
          default: sstate <= srx_pkg::SRX_LOS;
        endcase
      end
    end
  end

  always_ff @(posedge recovered_clock_a) begin
    if (rst_rx) begin
      word_bad <= 1'b0;
    end else if (ce_rx) begin
      if (word_end || align_now) begin
        word_bad <= 1'b0;
      end else begin
        word_bad <= word_bad || ch_cv;
      end
    end
  end

  // ===================================================================
  // 1:4 demultiplexer and word alignment
  logic force_d;
  logic force_rise;
  logic [1:0] slot;
  logic b9;
  logic word_pend;
  logic link_sync_q;
  logic aligned_q;
  logic [7:0] buf_byte [4];
  logic [3:0] buf_k;
  logic [3:0] buf_b9;
  logic [3:0] buf_mark;

  assign force_rise = force_lvl && !force_d;
  // commas outside a hunt never move the boundary
  assign align_now = synced && hunt && ch_comma
    && !no_align;
  assign slot = align_now ? srx_pkg::SLOT_LAST : srx_pkg::SLOT_LAST - phase;
  assign b9 = dec_en ? (ch_cv || !synced) : ch_b9;

  always_ff @(posedge recovered_clock_a) begin
    if (rst_rx) begin
      force_d <= 1'b0;
      hunt <= 1'b1;
    end else if (ce_rx) begin
      force_d <= force_lvl;
      // a new request beats a completed alignment in the same cycle
      if (!synced || force_rise) begin
        hunt <= 1'b1;
      end else if (align_now) begin
        hunt <= 1'b0;
      end
    end
  end

  always_ff @(posedge recovered_clock_a) begin
    if (rst_rx) begin
      phase <= '0;
      word_pend <= 1'b0;
    end else if (ce_rx) begin
      word_pend <= word_end;
      if (align_now) begin
        phase <= srx_pkg::PHASE_AFTER_ALIGN;
      end else begin
        phase <= phase + 2'h1;
      end
    end
  end

  always_ff @(posedge recovered_clock_a) begin
    if (rst_rx) begin
      buf_k <= '0;
      buf_b9 <= '0;
      buf_mark <= '0;
      for (int i = 0; i < 4; i++) begin
        buf_byte[i] <= '0;
      end
    end else if (ce_rx) begin
      buf_byte[slot] <= ch_byte;
      buf_k[slot] <= ch_b8;
      buf_b9[slot] <= b9;
      buf_mark[slot] <= synced && ch_comma;
    end
  end

  // buffer is read one cycle after the last slot fills, before reuse
  always_ff @(posedge recovered_clock_a) begin
    if (rst_rx) begin
      rx_word_out <= '0;
      rx_special_flags <= '0;
      rx_bit9_flags <= '0;
      align_marker_bits <= '0;
      rx_word_valid <= 1'b0;
    end else if (ce_rx) begin
      rx_word_valid <= word_pend;
      if (word_pend) begin
        rx_word_out <= {buf_byte[3], buf_byte[2],
                        buf_byte[1], buf_byte[0]};
        rx_special_flags <= buf_k;
        rx_bit9_flags <= buf_b9;
        // bypass mode feeds no lane aligner
        align_marker_bits <= (synced && dec_en) ? buf_mark
          : '0;
      end else if (!synced) begin
        align_marker_bits <= '0;
      end
    end
  end

  always_ff @(posedge recovered_clock_a) begin
    if (rst_rx) begin
      link_sync_q <= 1'b0;
      aligned_q <= 1'b0;
    end else if (ce_rx) begin
      link_sync_q <= synced;
      aligned_q <= synced && !hunt;
    end
  end

  assign serdes_link_sync = link_sync_q;

  // ===================================================================
  // status back into the register clock domain
  logic [2:0] st_meta;
  logic [2:0] st_sync;
  logic cdr_seen;
  logic [7:0] cdr_cnt;

  always_ff @(posedge clk) begin
    st_meta <= {link_sync_q, aligned_q, cdr_data_locked};
    st_sync <= st_meta;
  end

  assign cdr_seen = st_sync[0];

  always_ff @(posedge clk) begin
    if (reset) begin
      word_sync_status <= 1'b0;
      demux_sync_status <= 1'b0;
    end else if (clk_en) begin
      word_sync_status <= st_sync[2];
      demux_sync_status <= st_sync[1];
    end
  end

  // ===================================================================
  // clock recovery fallback: hold reference, then retry the data
  always_ff @(posedge clk) begin
    if (reset) begin
      cdr_lock_to_ref <= 1'b0;
      cdr_cnt <= '0;
    end else if (clk_en) begin
      if (cdr_seen) begin
        cdr_lock_to_ref <= 1'b0;
        cdr_cnt <= '0;
      end else if (!cdr_lock_to_ref && cdr_cnt == srx_pkg::RETRY_LAST) begin
        cdr_lock_to_ref <= 1'b1;
        cdr_cnt <= '0;
      end else if (cdr_lock_to_ref && cdr_cnt == srx_pkg::REF_HOLD_LAST) begin
        cdr_lock_to_ref <= 1'b0;
        cdr_cnt <= '0;
      end else begin
        cdr_cnt <= cdr_cnt + 8'h01;
      end
    end
  end

  // ===================================================================
  // group receive clock; select must be static, a change may glitch
  assign shared_rx_clock = peer_rx_clocks[rx_clock_select];

endmodule : srx_align_demux
`default_nettype wire

/* File: logic/srx_pkg.sv */
`default_nettype none
// =====================================================================
// shared constants for the receive alignment channel
package srx_pkg;

  // comma seen as {f,i,e,d,c,b,a}, first received bit in bit 0
  localparam logic [6:0] COMMA_POS = 7'h7C;
  localparam logic [6:0] COMMA_NEG = 7'h03;

  // abcdei images of the K28 group and fghj alternate-7 codes
  localparam logic [5:0] K28_NEG = 6'h0F;
  localparam logic [5:0] K28_POS = 6'h30;
  localparam logic [3:0] ALT7_NEG = 4'h7;
  localparam logic [3:0] ALT7_POS = 4'h8;

  // link state machine thresholds
  localparam logic [1:0] ACQ_SETS = 2'h3;
  localparam logic [2:0] LOSS_BAD = 3'h4;
  localparam logic [2:0] FC_GOOD = 3'h2;
  localparam logic [2:0] XAUI_GOOD = 3'h4;
  localparam logic MODE_XAUI = 1'b1;

  // demultiplexer slots: first character lands in the top slot
  localparam logic [1:0] SLOT_LAST = 2'h3;
  localparam logic [1:0] PHASE_AFTER_ALIGN = 2'h1;
  localparam logic [3:0] OFF_RESET = 4'h0;

  // clock recovery retry timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int RETRY_NS = 2000;
  localparam int REF_HOLD_NS = 5000;
  localparam int RETRY_CYC = (RETRY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REF_HOLD_CYC =
    (REF_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] RETRY_LAST = 8'(RETRY_CYC - 1);
  localparam logic [7:0] REF_HOLD_LAST = 8'(REF_HOLD_CYC - 1);

  typedef enum logic [1:0] {SRX_LOS, SRX_ACQ, SRX_SYNC} srx_sync_e;

  function automatic logic srx_is_comma(input logic [6:0] b);
    srx_is_comma = (b == COMMA_POS) || (b == COMMA_NEG);
  endfunction : srx_is_comma

  // abcdei groups that may carry a K code with an alternate-7 tail
  function automatic logic srx_kx7(input logic [5:0] c);
    srx_kx7 = c inside {6'h3A, 6'h05, 6'h36, 6'h09,
                        6'h2E, 6'h11, 6'h1E, 6'h21};
  endfunction : srx_kx7

  // returns {valid, EDCBA}; input is abcdei with a in the top bit
  function automatic logic [5:0] srx_dec6(input logic [5:0] c);
    logic ok;
    logic [4:0] x;
    ok = 1'b1;
    x = 5'h00;
    case (c)
      6'h27, 6'h18: x = 5'h00;
      6'h1D, 6'h22: x = 5'h01;
      6'h2D, 6'h12: x = 5'h02;
      6'h31: x = 5'h03;
      6'h35, 6'h0A: x = 5'h04;
      6'h29: x = 5'h05;
      6'h19: x = 5'h06;
      6'h38, 6'h07: x = 5'h07;
      6'h39, 6'h06: x = 5'h08;
      6'h25: x = 5'h09;
      6'h15: x = 5'h0A;
      6'h34: x = 5'h0B;
      6'h0D: x = 5'h0C;
      6'h2C: x = 5'h0D;
      6'h1C: x = 5'h0E;
      6'h17, 6'h28: x = 5'h0F;
      6'h1B, 6'h24: x = 5'h10;
      6'h23: x = 5'h11;
      6'h13: x = 5'h12;
      6'h32: x = 5'h13;
      6'h0B: x = 5'h14;
      6'h2A: x = 5'h15;
      6'h1A: x = 5'h16;
      6'h3A, 6'h05: x = 5'h17;
      6'h33, 6'h0C: x = 5'h18;
      6'h26: x = 5'h19;
      6'h16: x = 5'h1A;
      6'h36, 6'h09: x = 5'h1B;
      6'h0E, 6'h0F, 6'h30: x = 5'h1C;
      6'h2E, 6'h11: x = 5'h1D;
      6'h1E, 6'h21: x = 5'h1E;
      6'h2B, 6'h14: x = 5'h1F;
      default: ok = 1'b0;
    endcase
    srx_dec6 = {ok, x};
  endfunction : srx_dec6

  // returns {valid, HGF}; input is fghj with f in the top bit
  function automatic logic [3:0] srx_dec4(input logic [3:0] c);
    logic ok;
    logic [2:0] y;
    ok = 1'b1;
    y = 3'h0;
    case (c)
      4'hB, 4'h4: y = 3'h0;
      4'h9: y = 3'h1;
      4'h5: y = 3'h2;
      4'hC, 4'h3: y = 3'h3;
      4'hD, 4'h2: y = 3'h4;
      4'hA: y = 3'h5;
      4'h6: y = 3'h6;
      4'hE, 4'h1, 4'h7, 4'h8: y = 3'h7;
      default: ok = 1'b0;
    endcase
    srx_dec4 = {ok, y};
  endfunction : srx_dec4

endpackage : srx_pkg
`default_nettype wire

/* File: tb/srx_align_demux_asserts.sv */
`default_nettype none
// ====
// port checks of the receive alignment channel
module srx_align_demux_asserts (
  input wire logic clk,
  input wire logic reset,
  input wire logic cdr_data_locked,
  input wire logic cdr_lock_to_ref,
  input wire logic word_sync_status,
  input wire logic demux_sync_status,
  input wire logic shared_rx_clock,
  input wire logic [1:0] rx_clock_select,
  input wire logic [3:0] peer_rx_clocks,
  input wire logic recovered_clock_a,
  input wire logic rx_decode_enable,
  input wire logic serdes_link_sync,
  input wire logic code_violation_flag,
  input wire logic [31:0] rx_word_out,
  input wire logic [3:0] rx_special_flags,
  input wire logic [3:0] rx_bit9_flags,
  input wire logic [3:0] align_marker_bits,
  input wire logic rx_word_valid
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int HOLD = srx_pkg::REF_HOLD_CYC;
  logic [7:0] ref_run;
  logic [3:0] cv_age;
  always_ff @(posedge clk) begin
    if (reset || !cdr_lock_to_ref) ref_run <= 8'h00;
    else ref_run <= ref_run + 8'h01;
  end
  // saturates so a long clean run never wraps back to fresh
  always_ff @(posedge recovered_clock_a) begin
    if (reset || code_violation_flag) cv_age <= 4'h0;
    else if (cv_age != 4'hF) cv_age <= cv_age + 4'h1;
  end
  // ====
  // sequences
  sequence s_nosync3;
    !serdes_link_sync [*3];
  endsequence
  sequence s_raw16;
    !rx_decode_enable [*8] ##1 !rx_decode_enable [*8];
  endsequence
  sequence s_los16;
    (rx_decode_enable && !serdes_link_sync) [*8] ##1
      (rx_decode_enable && !serdes_link_sync) [*8];
  endsequence
  // ====
  // properties
  chk_marker_clear: assert property (@(posedge recovered_clock_a)
    disable iff (reset) s_nosync3 |-> align_marker_bits == 4'h0)
    else $error("markers set without sync");
  chk_raw_markers: assert property (@(posedge recovered_clock_a)
    disable iff (reset) s_raw16 |-> align_marker_bits == 4'h0)
    else $error("markers set in raw mode");
  chk_valid_pulse: assert property (@(posedge recovered_clock_a)
    disable iff (reset) rx_word_valid |=> !rx_word_valid)
    else $error("word valid longer than one cycle");
  chk_word_stands: assert property (@(posedge recovered_clock_a)
    disable iff (reset) !rx_word_valid |-> $stable(rx_word_out) &&
    $stable(rx_special_flags) && $stable(rx_bit9_flags))
    else $error("word changed without valid");
  chk_bit9_los: assert property (@(posedge recovered_clock_a)
    disable iff (reset) s_los16 ##0 rx_word_valid |-> rx_bit9_flags == 4'hF)
    else $error("bit9 clear while out of sync");
  chk_loss_cause: assert property (@(posedge recovered_clock_a)
    disable iff (reset) $fell(serdes_link_sync) |-> cv_age < 4'hC)
    else $error("sync lost without violations");
  chk_lock_clear: assert property (@(posedge clk)
    disable iff (reset) cdr_data_locked [*4] |-> !cdr_lock_to_ref)
    else $error("reference lock while locked");
  chk_ref_hold: assert property (@(posedge clk)
    disable iff (reset) $fell(cdr_lock_to_ref) |->
    ref_run == 8'(HOLD) || $past(cdr_data_locked, 3))
    else $error("reference hold length wrong");
  chk_demux_sync: assert property (@(posedge clk)
    disable iff (reset) demux_sync_status |->
    word_sync_status || $past(word_sync_status))
    else $error("word aligned without sync");
  chk_clock_mux: assert property (@(posedge clk)
    disable iff (reset) shared_rx_clock == peer_rx_clocks[rx_clock_select])
    else $error("shared clock from wrong channel");
endmodule : srx_align_demux_asserts
bind srx_align_demux srx_align_demux_asserts i_chk (.clk, .reset,
  .cdr_data_locked, .cdr_lock_to_ref, .word_sync_status,
  .demux_sync_status, .shared_rx_clock, .rx_clock_select, .peer_rx_clocks,
  .recovered_clock_a, .rx_decode_enable, .serdes_link_sync,
  .code_violation_flag, .rx_word_out, .rx_special_flags, .rx_bit9_flags,
  .align_marker_bits, .rx_word_valid);
`default_nettype wire

/* File: tb/srx_far_tx.sv */
`default_nettype none
// ====
// remote transmitter: idle ordered sets on a slipped bit grid
module srx_far_tx (
  input wire logic lclk,
  input wire logic bad,
  input wire logic quiet,
  input wire logic slip,
  input wire logic [3:0] offset,
  output logic [9:0] bits
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [9:0] cur = 10'h155;
  logic [9:0] nxt = 10'h155;
  logic [1:0] pos = 2'h0;
  logic neg = 1'b1;
  logic done = 1'b0;
  // offset models where the deserializer cut the serial stream
  assign bits = 10'({nxt, cur} >> offset);
  always @(negedge lclk) begin
    cur <= nxt;
    if (slip && !done && pos == 2'h3) begin
      done <= 1'b1;
      nxt <= 10'h155;
    end else begin
      pos <= pos + 2'h1;
      if (!slip) done <= 1'b0;
      if (pos == 2'h0 && !quiet) begin
        nxt <= neg ? 10'h17C : 10'h283;
        neg <= !neg;
      end else nxt <= bad ? 10'h000 : 10'h155;
    end
  end
endmodule : srx_far_tx
`default_nettype wire

/* File: tb/test_srx_align_demux.sv */
`default_nettype none
`define CHK(a, b, m) begin \
  comparisons++; \
  if ((a) !== (b)) begin \
    mismatches++; \
    $display("[FAIL] %0t %s", $time, m); \
  end \
end
module test_srx_align_demux;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [31:0] WORD = 32'hBCB5_B5B5;
  logic clk, reset, byte_sync_enable, protocol_mode_select;
  logic rx_decode_enable, force_word_realign, disable_word_align;
  logic [1:0] rx_clock_select;
  logic [3:0] peer_rx_clocks, offset, rx_special_flags, rx_bit9_flags;
  logic [3:0] align_marker_bits;
  logic cdr_data_locked, cdr_lock_to_ref, word_sync_status;
  logic demux_sync_status, shared_rx_clock, recovered_clock_a;
  logic serdes_link_sync, comma_detect_flag, code_violation_flag;
  logic rx_word_valid, bad, quiet, slip, clk_en;
  logic [9:0] rx_deser_bits;
  logic [31:0] rx_word_out;
  int mismatches, comparisons;
  srx_align_demux i_dut (.clk, .reset, .clk_en, .byte_sync_enable,
    .protocol_mode_select, .rx_decode_enable, .force_word_realign,
    .disable_word_align, .rx_clock_select, .peer_rx_clocks,
    .cdr_data_locked, .cdr_lock_to_ref, .word_sync_status,
    .demux_sync_status, .shared_rx_clock, .recovered_clock_a,
    .rx_deser_bits, .serdes_link_sync, .comma_detect_flag,
    .code_violation_flag, .rx_word_out, .rx_special_flags, .rx_bit9_flags,
    .align_marker_bits, .rx_word_valid);
  srx_far_tx i_far (.lclk(recovered_clock_a), .bad, .quiet, .slip,
    .offset, .bits(rx_deser_bits));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    recovered_clock_a = 1'b0;
    #7;
    forever #15 recovered_clock_a = ~recovered_clock_a;
  end
  // ====
  // helpers
  task automatic nclk(input int n);
    repeat (n) @(negedge clk);
  endtask : nclk
  task automatic do_reset();
    reset = 1'b1;
    nclk(20);
    reset = 1'b0;
    nclk(2);
  endtask : do_reset
  task automatic next_word();
    int i;
    i = 0;
    do begin
      @(negedge recovered_clock_a);
      i++;
    end while (rx_word_valid !== 1'b1 && i < 40);
  endtask : next_word
  task automatic seek(input logic [3:0] m, input int n);
    int i;
    for (i = 0; i < n; i++) begin
      next_word();
      if (align_marker_bits === m) break;
    end
  endtask : seek
  task automatic lsync(input logic v);
    int i;
    for (i = 0; i < 400 && serdes_link_sync !== v; i++)
      @(negedge recovered_clock_a);
  endtask : lsync
  // ====
  // scenarios
  task automatic t_fc();
    `CHK(align_marker_bits, 4'h0, "reset markers")
    `CHK(word_sync_status, 1'b0, "reset sync")
    lsync(1'b1);
    `CHK(serdes_link_sync, 1'b1, "fc sync")
    seek(4'h8, 8);
    `CHK(align_marker_bits, 4'h8, "fc marker")
    `CHK(rx_word_out, WORD, "fc word")
    `CHK(rx_special_flags, 4'h8, "fc special")
    `CHK(rx_bit9_flags, 4'h0, "fc bit9")
    nclk(4);
    `CHK(demux_sync_status, 1'b1, "demux sync")
  endtask : t_fc
  task automatic t_slip();
    slip = 1'b1;
    seek(4'h4, 8);
    repeat (2) next_word();
    `CHK(align_marker_bits, 4'h4, "slip marker")
    `CHK(rx_word_out, 32'hB5BC_B5B5, "slip word")
    slip = 1'b0;
  endtask : t_slip
  task automatic t_force();
    disable_word_align = 1'b1;
    nclk(2);
    force_word_realign = 1'b1;
    seek(4'h8, 6);
    `CHK(align_marker_bits, 4'h4, "frozen boundary")
    force_word_realign = 1'b0;
    disable_word_align = 1'b0;
    nclk(2);
    force_word_realign = 1'b1;
    seek(4'h8, 8);
    `CHK(align_marker_bits, 4'h8, "forced marker")
    `CHK(rx_word_out, WORD, "forced word")
    force_word_realign = 1'b0;
  endtask : t_force
  task automatic t_loss();
    bad = 1'b1;
    repeat (8) @(negedge recovered_clock_a);
    `CHK(serdes_link_sync, 1'b1, "early loss")
    slip = 1'b1;
    lsync(1'b0);
    `CHK(serdes_link_sync, 1'b0, "loss")
    repeat (4) @(negedge recovered_clock_a);
    `CHK(align_marker_bits, 4'h0, "markers at loss")
    bad = 1'b0;
    slip = 1'b0;
    lsync(1'b1);
    seek(4'h8, 8);
    `CHK(align_marker_bits, 4'h8, "resync marker")
    `CHK(rx_word_out, WORD, "resync word")
  endtask : t_loss
  task automatic t_byte();
    quiet = 1'b1;
    byte_sync_enable = 1'b0;
    offset = 4'h6;
    nclk(1);
    quiet = 1'b0;
    repeat (60) @(negedge recovered_clock_a);
    `CHK(serdes_link_sync, 1'b0, "no align when off")
    quiet = 1'b1;
    nclk(1);
    byte_sync_enable = 1'b1;
    nclk(2);
    byte_sync_enable = 1'b0;
    nclk(2);
    quiet = 1'b0;
    lsync(1'b1);
    `CHK(serdes_link_sync, 1'b1, "owed alignment")
    byte_sync_enable = 1'b1;
    offset = 4'h3;
    repeat (100) @(negedge recovered_clock_a);
    `CHK(serdes_link_sync, 1'b1, "realign on comma")
  endtask : t_byte
  task automatic t_cdr();
    int n;
    cdr_data_locked = 1'b0;
    for (n = 0; n < 40 && cdr_lock_to_ref !== 1'b1; n++) nclk(1);
    for (n = 0; n < 80 && cdr_lock_to_ref === 1'b1; n++) nclk(1);
    `CHK(n, srx_pkg::REF_HOLD_CYC, "reference hold")
    for (n = 0; n < 40 && cdr_lock_to_ref !== 1'b1; n++) nclk(1);
    `CHK(cdr_lock_to_ref, 1'b1, "retry")
    cdr_data_locked = 1'b1;
    nclk(4);
    `CHK(cdr_lock_to_ref, 1'b0, "locked to data")
  endtask : t_cdr
  task automatic t_mux();
    int i;
    // freeze just after a word so the valid pulse is already low
    next_word();
    clk_en = 1'b0;
    nclk(10);
    `CHK(rx_word_valid, 1'b0, "frozen valid")
    `CHK(word_sync_status, 1'b1, "frozen sync")
    clk_en = 1'b1;
    for (i = 0; i < 4; i++) begin
      rx_clock_select = 2'(i);
      peer_rx_clocks = 4'h1 << i;
      nclk(1);
      `CHK(shared_rx_clock, 1'b1, "clock select")
      peer_rx_clocks = ~(4'h1 << i);
      nclk(1);
      `CHK(shared_rx_clock, 1'b0, "clock select")
    end
  endtask : t_mux
  task automatic t_xaui();
    protocol_mode_select = 1'b1;
    rx_decode_enable = 1'b1;
    do_reset();
    lsync(1'b1);
    `CHK(serdes_link_sync, 1'b1, "xaui sync")
    seek(4'h8, 8);
    `CHK(align_marker_bits, 4'h8, "xaui marker")
    `CHK(rx_word_out, WORD, "xaui word")
  endtask : t_xaui
  task automatic t_raw();
    logic [3:0] es, e9;
    int k, n;
    rx_decode_enable = 1'b0;
    protocol_mode_select = 1'b0;
    do_reset();
    repeat (12) next_word();
    n = 0;
    for (k = 0; k < 4; k++) begin
      n += (rx_word_out[8*k+:8] === 8'h55);
      es[k] = rx_word_out[8*k+:8] inside {8'h55, 8'h7C};
      e9[k] = rx_word_out[8*k+:8] === 8'h83;
    end
    `CHK(n, 3, "raw data bytes")
    `CHK(rx_special_flags, es, "raw bit8")
    `CHK(rx_bit9_flags, e9, "raw bit9")
    `CHK(align_marker_bits, 4'h0, "raw markers")
  endtask : t_raw
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : complete_run
  initial begin
    reset = 1'b1;
    clk_en = 1'b1;
    byte_sync_enable = 1'b1;
    protocol_mode_select = 1'b0;
    rx_decode_enable = 1'b1;
    force_word_realign = 1'b0;
    disable_word_align = 1'b0;
    rx_clock_select = 2'h0;
    peer_rx_clocks = 4'h0;
    cdr_data_locked = 1'b1;
    offset = 4'h3;
    bad = 1'b0;
    quiet = 1'b0;
    slip = 1'b0;
    do_reset();
    t_fc();
    t_slip();
    t_force();
    t_loss();
    t_byte();
    t_cdr();
    t_mux();
    t_xaui();
    t_raw();
    complete_run();
  end
  // scenarios need about 32 us (some 320 clk cycles); this leaves a wide margin
  initial begin
    #2_000_000;
    mismatches++;
    complete_run();
  end
endmodule : test_srx_align_demux
`default_nettype wire
